//--- src/fgpwm_pkg.sv
/*
 Constants, register map and helper functions for the four-group PWM block.
 Assumes a single 200 MHz clock and an APB master on the register side.
*/
// How it works
// RULE_01: Four independent PWM channels, one per group.
// RULE_02: Frequency valid from 10 Hz to 2.5 kHz.
// RULE_03: Duty is percent of period driven on.
// RULE_04: Duty valid between delay*freq and 100-delay*freq.
// RULE_05: Software writes settings before raising update request.
// RULE_06: Update request bits sit at 0,4,8,12.
// RULE_07: Bits 1,5,9,13 trigger read-back of preset values.
// RULE_08: Completion bits 0,4,8,12 report update done.
// RULE_09: Completion bits 1,5,9,13 report read-back done.
// RULE_10: Request seen: apply parameters, then set completion.
// RULE_11: Software clears request only after seeing completion.
// RULE_12: Completion clears only once request returns to zero.
// RULE_13: One request applies frequency and duty together.
// RULE_14: Invalid settings rejected, old parameters keep running.
// RULE_15: Alarm also reports error code 842.
// RULE_16: Two alarm bits per group: frequency, duty.
// RULE_17: Alarm bits 0..7 by group, 8..15 unused.
// RULE_18: Control field bit 0 starts and stops channel.
// RULE_19: Status field bit 0 shows channel running.
// RULE_20: Period and on-time counters from own clock.
// RULE_21: New parameters start at next period boundary.
`default_nettype none
package fgpwm_pkg;
	// ==========================================
	// Timing and setting limits
	localparam int unsigned CLK_HZ = 32'h0BEB_C200;
	localparam int unsigned FREQ_MIN_HZ = 32'h0000_000A;
	localparam int unsigned FREQ_MAX_HZ = 32'h0000_09C4;
	localparam int unsigned DUTY_FULL = 32'h0000_0064;
	localparam int unsigned HW_DELAY_US = 32'h0000_0028;
	localparam int unsigned DUTY_SCALE = 32'h0000_2710;
	localparam int unsigned FULL_SCALE = 32'h000F_4240;
	localparam int PER_W = 25;
	localparam int NGRP = 4;
	localparam int GRP_STRIDE = 4;
	localparam int UPD_BIT = 0;
	localparam int RD_BIT = 1;
	localparam logic [15:0] REQ_MASK = 16'h2222 | 16'h1111;
	localparam logic [15:0] ERR_PARAM = 16'h034A;
	// ==========================================
	// Reset values
	localparam logic [15:0] DEF_FREQ = 16'h000A;
	localparam logic [7:0] DEF_DUTY = 8'h32;
	localparam logic [PER_W-1:0] DEF_PERIOD = 25'h131_2D00;
	localparam logic [PER_W-1:0] DEF_ON = 25'h098_9680;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_FREQ = 8'h00;
	localparam logic [7:0] OFS_DUTY = 8'h10;
	localparam logic [7:0] OFS_REQ = 8'h20;
	localparam logic [7:0] OFS_DONE = 8'h24;
	localparam logic [7:0] OFS_ALARM = 8'h28;
	localparam logic [7:0] OFS_CTRL = 8'h2C;
	localparam logic [7:0] OFS_STAT = 8'h30;
	localparam logic [7:0] OFS_IOERR = 8'h34;
	localparam logic [7:0] OFS_RB = 8'h40;
	// ==========================================
	// Helpers
	// Frequency inside the allowed span
	function automatic logic freq_ok(input logic [15:0] f);
		return (32'(f) >= FREQ_MIN_HZ) && (32'(f) <= FREQ_MAX_HZ); // RULE_02
	endfunction
	// Duty inside the effective range for this frequency
	function automatic logic duty_ok(input logic [15:0] f, input logic [7:0] d);
		logic [31:0] lim;
		logic [31:0] dv;
		lim = HW_DELAY_US * 32'(f);
		dv = 32'(d) * DUTY_SCALE;
		return (lim <= FULL_SCALE) && (dv >= lim) && (dv <= FULL_SCALE - lim); // RULE_04
	endfunction
	// Clock cycles per output period
	function automatic logic [PER_W-1:0] period_of(input logic [15:0] f);
		return (f == 16'h0000) ? '0 : PER_W'(CLK_HZ / 32'(f)); // RULE_20
	endfunction
	// Clock cycles of on-time within a period
	function automatic logic [PER_W-1:0] on_of(input logic [PER_W-1:0] p, input logic [7:0] d);
		return PER_W'((32'(p) * 32'(d)) / DUTY_FULL); // RULE_03
	endfunction
endpackage
`default_nettype wire

//--- src/fgpwm_chan.sv
/*
 One PWM channel: one period counter, compared against the on-time, with staged settings.
 Assumes load pulses come from the register block on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fgpwm_chan (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic load,
	input wire logic [fgpwm_pkg::PER_W-1:0] per,
	input wire logic [fgpwm_pkg::PER_W-1:0] on_cyc,
	// Outputs
	output logic pwm_q,
	output logic running_q
);
	import fgpwm_pkg::*;
	// ==========================================
	// State
	logic [PER_W-1:0] stage_per_q; // Staged period
	logic [PER_W-1:0] stage_on_q; // Staged on-time
	logic pend_q; // Staged values waiting
	logic [PER_W-1:0] cur_per_q; // Active period
	logic [PER_W-1:0] cur_on_q; // Active on-time
	logic [PER_W-1:0] cnt_q; // Position in period
	logic wrap; // Period boundary
	assign wrap = (run && !running_q) || (running_q && (cnt_q >= cur_per_q - PER_W'(1)));
	// Stage new settings, load wins over consume
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_per_q <= DEF_PERIOD;
			stage_on_q <= DEF_ON;
			pend_q <= 1'b0;
		end else if (load) begin
			stage_per_q <= per;
			stage_on_q <= on_cyc;
			pend_q <= 1'b1;
		end else if (wrap) begin
			pend_q <= 1'b0;
		end
	end
	// Take staged values only at a boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_per_q <= DEF_PERIOD;
			cur_on_q <= DEF_ON;
		end else if (wrap && pend_q) begin
			cur_per_q <= stage_per_q; // RULE_21
			cur_on_q <= stage_on_q; // RULE_21
		end
	end
	// Period counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (!run || wrap) begin
			cnt_q <= '0; // RULE_20
		end else begin
			cnt_q <= cnt_q + PER_W'(1); // RULE_20
		end
	end
	// Output level and running flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_q <= 1'b0;
			running_q <= 1'b0;
		end else begin
			running_q <= run; // RULE_19
			pwm_q <= run && running_q && !wrap && (cnt_q < cur_on_q); // RULE_03
		end
	end
endmodule
`default_nettype wire

//--- src/fgpwm_top.sv
/*
 Four-group PWM block with APB register access, update and read-back
 handshakes, parameter alarms and run control.
 Assumes an APB master on pclk; PWM outputs drive external load drivers.
*/
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fgpwm_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// PWM outputs
	output logic [3:0] pwm_out
);
	import fgpwm_pkg::*;

	// ==========================================
	// Software settings
	logic [15:0] freq_q [NGRP]; // Pending frequency, Hz
	logic [7:0] duty_q [NGRP]; // Pending duty, percent
	logic [15:0] req_q; // Update and read requests
	logic [15:0] done_q; // Completion word
	logic [15:0] alarm_q; // Alarm word
	logic [15:0] ctrl_q; // Run control word
	logic [15:0] ioerr_q; // General I/O error code
	// Active and read-back values
	logic [15:0] act_freq_q [NGRP]; // Frequency in use
	logic [7:0] act_duty_q [NGRP]; // Duty in use
	logic [15:0] rb_freq_q [NGRP]; // Read-back frequency
	logic [7:0] rb_duty_q [NGRP]; // Read-back duty
	// Channel loading
	logic [NGRP-1:0] load_q; // One-cycle load pulse
	logic [PER_W-1:0] new_per_q [NGRP]; // Period to load
	logic [PER_W-1:0] new_on_q [NGRP]; // On-time to load
	// Channel state
	logic [NGRP-1:0] run_st; // Channel running
	logic [NGRP-1:0] pwm_raw; // Channel output flops
	// Bus registers
	logic [31:0] prdata_q; // Read data
	logic pready_q; // Ready
	logic pslverr_q; // Error
	// Handshake decode
	logic [NGRP-1:0] upd_go; // Update request newly seen
	logic [NGRP-1:0] rd_go; // Read request newly seen
	logic [NGRP-1:0] f_ok; // Pending frequency valid
	logic [NGRP-1:0] d_ok; // Pending duty valid
	logic setup_ph; // APB setup cycle
	logic wr_acc; // APB write completes
	logic [1:0] grp; // Group from address
	logic [32:0] rw; // Decoded word at the bus address, top bit set when mapped

	// ==========================================
	// Bus phase decode
	assign setup_ph = psel && !penable && !pready_q;
	assign wr_acc = psel && penable && pwrite && pready_q;
	assign grp = paddr[3:2];

	// Register word at an address, zero when unmapped
	function automatic logic [32:0] read_word(input logic [7:0] a);
		logic [1:0] g;
		g = a[3:2];
		read_word = '0;
		case (a[7:4])
			OFS_FREQ[7:4]: read_word = {1'b1, 16'h0000, freq_q[g]};
			OFS_DUTY[7:4]: read_word = {1'b1, 24'h00_0000, duty_q[g]};
			OFS_RB[7:4]: read_word = {1'b1, 8'h00, rb_duty_q[g], rb_freq_q[g]};
			OFS_REQ[7:4]: begin
				case (a)
					OFS_REQ: read_word = {1'b1, 16'h0000, req_q};
					OFS_DONE: read_word = {1'b1, 16'h0000, done_q};
					OFS_ALARM: read_word = {1'b1, 16'h0000, alarm_q};
					OFS_CTRL: read_word = {1'b1, 16'h0000, ctrl_q};
					default: read_word = '0;
				endcase
			end
			OFS_STAT[7:4]: begin
				case (a)
					OFS_STAT: read_word = {1'b1, 16'h0000, stat_word(run_st)};
					OFS_IOERR: read_word = {1'b1, 16'h0000, ioerr_q};
					default: read_word = '0;
				endcase
			end
			default: read_word = '0;
		endcase
		if (a[1:0] != 2'b00) begin
			read_word = '0;
		end
	endfunction

	// Spread one bit per group into bit 0 of each nibble
	function automatic logic [15:0] stat_word(input logic [NGRP-1:0] s);
		stat_word = '0;
		for (int i = 0; i < NGRP; i++) begin
			stat_word[i*GRP_STRIDE] = s[i]; // RULE_19
		end
	endfunction

	// Decode once; a bit select on a call result is not legal
	always_comb begin
		rw = read_word(paddr);
	end
	// ==========================================
	// APB handshake: ready one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup_ph;
			pslverr_q <= setup_ph && !rw[32];
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (setup_ph && !pwrite) begin
			prdata_q <= rw[31:0];
		end
	end

	// ==========================================
	// Frequency and duty setting registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NGRP; i++) begin
				freq_q[i] <= DEF_FREQ;
				duty_q[i] <= DEF_DUTY;
			end
		end else if (wr_acc && !pslverr_q) begin
			// Settings are staged here, not used until requested
			if (paddr[7:4] == OFS_FREQ[7:4]) begin
				freq_q[grp] <= pwdata[15:0];
			end else if (paddr[7:4] == OFS_DUTY[7:4]) begin
				duty_q[grp] <= pwdata[7:0];
			end
		end
	end

	// Request word, unused bits forced to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_q <= '0;
		end else if (wr_acc && !pslverr_q && paddr == OFS_REQ) begin
			req_q <= pwdata[15:0] & REQ_MASK; // RULE_06
		end
	end

	// Run control word, one start bit per group
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= '0;
		end else if (wr_acc && !pslverr_q && paddr == OFS_CTRL) begin
			ctrl_q <= pwdata[15:0] & 16'h1111; // RULE_18
		end
	end

	// ==========================================
	// Request decode per group
	always_comb begin
		for (int i = 0; i < NGRP; i++) begin
			upd_go[i] = req_q[i*GRP_STRIDE+UPD_BIT] && !done_q[i*GRP_STRIDE+UPD_BIT]; // RULE_10
			rd_go[i] = req_q[i*GRP_STRIDE+RD_BIT] && !done_q[i*GRP_STRIDE+RD_BIT]; // RULE_07
			f_ok[i] = freq_ok(freq_q[i]); // RULE_02
			d_ok[i] = duty_ok(freq_q[i], duty_q[i]); // RULE_04
		end
	end

	// Completion word: set on service, clear once request drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= '0;
		end else begin
			for (int i = 0; i < NGRP; i++) begin
				if (upd_go[i]) begin
					done_q[i*GRP_STRIDE+UPD_BIT] <= 1'b1; // RULE_08
				end else if (!req_q[i*GRP_STRIDE+UPD_BIT]) begin
					done_q[i*GRP_STRIDE+UPD_BIT] <= 1'b0; // RULE_12
				end
				if (rd_go[i]) begin
					done_q[i*GRP_STRIDE+RD_BIT] <= 1'b1; // RULE_09
				end else if (!req_q[i*GRP_STRIDE+RD_BIT]) begin
					done_q[i*GRP_STRIDE+RD_BIT] <= 1'b0; // RULE_12
				end
			end
		end
	end

	// Apply both settings together when both are valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NGRP; i++) begin
				act_freq_q[i] <= DEF_FREQ;
				act_duty_q[i] <= DEF_DUTY;
				new_per_q[i] <= DEF_PERIOD;
				new_on_q[i] <= DEF_ON;
			end
			load_q <= '0;
		end else begin
			for (int i = 0; i < NGRP; i++) begin
				// Invalid pair leaves the running values alone
				load_q[i] <= upd_go[i] && f_ok[i] && d_ok[i]; // RULE_14
				if (upd_go[i] && f_ok[i] && d_ok[i]) begin
					act_freq_q[i] <= freq_q[i]; // RULE_13
					act_duty_q[i] <= duty_q[i]; // RULE_13
					new_per_q[i] <= period_of(freq_q[i]); // RULE_20
					new_on_q[i] <= on_of(period_of(freq_q[i]), duty_q[i]); // RULE_20
				end
			end
		end
	end

	// Alarm word: judged afresh on each update request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q <= '0;
		end else begin
			for (int i = 0; i < NGRP; i++) begin
				if (upd_go[i]) begin
					alarm_q[2*i] <= !f_ok[i]; // RULE_16 RULE_17
					alarm_q[2*i+1] <= !d_ok[i]; // RULE_16 RULE_17
				end
			end
		end
	end

	// Error code: alarm sets it, a write clears it, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ioerr_q <= '0;
		end else if (|(upd_go & ~(f_ok & d_ok))) begin
			ioerr_q <= ERR_PARAM; // RULE_15
		end else if (wr_acc && !pslverr_q && paddr == OFS_IOERR) begin
			ioerr_q <= '0;
		end
	end

	// Read-back copies the parameters now in use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NGRP; i++) begin
				rb_freq_q[i] <= '0;
				rb_duty_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NGRP; i++) begin
				if (rd_go[i]) begin
					rb_freq_q[i] <= act_freq_q[i]; // RULE_07
					rb_duty_q[i] <= act_duty_q[i]; // RULE_07
				end
			end
		end
	end

	// ==========================================
	// Four independent channels
	for (genvar g = 0; g < NGRP; g++) begin : g_chan
		fgpwm_chan u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.run(ctrl_q[g*GRP_STRIDE]), // RULE_18
			.load(load_q[g]),
			.per(new_per_q[g]),
			.on_cyc(new_on_q[g]),
			.pwm_q(pwm_raw[g]), // RULE_01
			.running_q(run_st[g])
		);
	end

	// Outputs straight from flops
	assign pwm_out = pwm_raw;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Update seen on group 0
	sequence s_upd_seen;
		req_q[0] && !done_q[0];
	endsequence
	// Request withdrawn while completion shows
	sequence s_upd_drop;
		!req_q[0] && done_q[0];
	endsequence

	property p_done_after_req;
		s_upd_seen |=> done_q[0];
	endproperty
	a_done_after_req: assert property (p_done_after_req) // RULE_10
		else $error("completion not set after update request");

	property p_done_clears;
		s_upd_drop |=> !done_q[0];
	endproperty
	a_done_clears: assert property (p_done_clears) // RULE_12
		else $error("completion not cleared after request drop");

	property p_done_holds;
		done_q[4] && req_q[4] |=> done_q[4];
	endproperty
	a_done_holds: assert property (p_done_holds) // RULE_12
		else $error("completion dropped while request still high");

	property p_bad_keeps;
		upd_go[1] && !(f_ok[1] && d_ok[1]) |=> $stable(act_freq_q[1]) && $stable(act_duty_q[1]) && !load_q[1];
	endproperty
	a_bad_keeps: assert property (p_bad_keeps) // RULE_14
		else $error("invalid setting changed active parameters");

	property p_freq_alarm;
		upd_go[2] && (32'(freq_q[2]) > FREQ_MAX_HZ) |=> alarm_q[4];
	endproperty
	a_freq_alarm: assert property (p_freq_alarm) // RULE_16
		else $error("frequency alarm missing");

	property p_duty_alarm;
		upd_go[3] |=> alarm_q[7] == !$past(d_ok[3]);
	endproperty
	a_duty_alarm: assert property (p_duty_alarm) // RULE_04
		else $error("duty alarm wrong");

	property p_err_code;
		upd_go[0] && !f_ok[0] |=> ioerr_q == ERR_PARAM && alarm_q[0];
	endproperty
	a_err_code: assert property (p_err_code) // RULE_15
		else $error("error code not reported with alarm");

	property p_stop;
		!ctrl_q[0] |=> !pwm_out[0] && !run_st[0];
	endproperty
	a_stop: assert property (p_stop) // RULE_18
		else $error("channel output while stopped");

	property p_running;
		ctrl_q[8] ##1 ctrl_q[8] |-> run_st[2];
	endproperty
	a_running: assert property (p_running) // RULE_19
		else $error("status does not show running");

	property p_readback;
		rd_go[0] |=> done_q[1] && rb_freq_q[0] == $past(act_freq_q[0]);
	endproperty
	a_readback: assert property (p_readback) // RULE_09
		else $error("read-back not completed");

	property p_req_layout;
		(req_q & ~REQ_MASK) == 16'h0000 && alarm_q[15:8] == 8'h00;
	endproperty
	a_req_layout: assert property (p_req_layout) // RULE_06
		else $error("unused request or alarm bits set");

	property p_apb_ready;
		setup_ph |=> pready ##1 !pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready)
		else $error("ready not one cycle after setup");
endmodule
`default_nettype wire

//--- tb/fgpwm_load.sv
/*
 Model of the external loads on the four PWM terminals.
 Assumes one sample per pclk cycle; records the first pulse width and period.
*/
`timescale 1ns/1ps
`default_nettype none
module fgpwm_load (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Driven terminals
	input wire logic [3:0] pwm_out,
	// Measurements of the first period
	output logic [31:0] hi_w [4],
	output logic [31:0] per_w [4],
	output logic [3:0] per_seen
);
	// ==========================================
	// Edge timing per terminal
	logic [31:0] cnt_q [4]; // Cycles since the last rise
	logic [3:0] last_q; // Level seen one cycle earlier
	logic [3:0] rose_q; // A first rise was seen
	// Only the first pulse is kept, so a later glitch cannot hide a bad one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_q <= 4'h0;
			rose_q <= 4'h0;
			per_seen <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= 32'h0000_0000;
				hi_w[i] <= 32'h0000_0000;
				per_w[i] <= 32'h0000_0000;
			end
		end else begin
			last_q <= pwm_out;
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
				// Rise: close the period, restart the count
				if (pwm_out[i] && !last_q[i]) begin
					cnt_q[i] <= 32'h0000_0001;
					rose_q[i] <= 1'b1;
					if (rose_q[i] && !per_seen[i]) begin
						per_w[i] <= cnt_q[i];
						per_seen[i] <= 1'b1;
					end
				end
				// Fall: width of the on-time
				if (!pwm_out[i] && last_q[i] && !per_seen[i]) begin
					hi_w[i] <= cnt_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
 Self-checking bench for the four-group PWM block over APB.
 Assumes a 200 MHz pclk and the load model beside the PWM terminals.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fgpwm_pkg::*;
	// ==========================================
	// Signals and counters
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pwm_out, per_seen;
	logic [31:0] hi_w [4];
	logic [31:0] per_w [4];
	logic err;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	// Row of the register table: direction, address, data, expected answer
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic e;} fgpwm_row_t;
	fgpwm_row_t rows [14] = '{
		'{1'b0, 8'h00, 32'h0, 32'h0000_000A, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h0000_000A, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h0000_0032, 1'b0}, '{1'b0, 8'h1C, 32'h0, 32'h0000_0032, 1'b0},
		'{1'b0, 8'h20, 32'h0, 32'h0000_0000, 1'b0}, '{1'b0, 8'h24, 32'h0, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h28, 32'h0, 32'h0000_0000, 1'b0}, '{1'b0, 8'h30, 32'h0, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h34, 32'h0, 32'h0000_0000, 1'b0}, '{1'b0, 8'h50, 32'h0, 32'h0000_0000, 1'b1},
		'{1'b0, 8'h02, 32'h0, 32'h0000_0000, 1'b1}, '{1'b1, 8'h24, 32'hFFFF_FFFF, 32'h0, 1'b0},
		'{1'b0, 8'h24, 32'h0, 32'h0000_0000, 1'b0}, '{1'b1, 8'h60, 32'h0000_0001, 32'h0, 1'b1}};
	// Bad settings: group, frequency, duty, cumulative alarm word
	int bad [4][4] = '{'{0, 3000, 50, 'h01}, '{1, 9, 50, 'h05}, '{2, 3000, 95, 'h35},
		'{3, 2500, 9, 'hB5}};
	int duty [4] = '{10, 25, 50, 90};
	// ==========================================
	// Design and load model
	fgpwm_top u_fgpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_out(pwm_out));
	fgpwm_load u_fgpwm_load (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out), .hi_w(hi_w),
		.per_w(per_w), .per_seen(per_seen));
	// ==========================================
	// Clock and hang guard
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 100000) begin
			n_errors++;
			end_of_test();
		end
	end
	// ==========================================
	// Tasks
	// Compare a seen value with the expected one
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; waits for pready with the request held
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Request and completion handshake for one bit of group g
	task automatic hs(input int g, input int b);
		int idx;
		idx = 4 * g + b;
		apb(1'b1, OFS_REQ, 32'(1) << idx);
		// Always read once, so stale data from an earlier read cannot end the poll
		apb(1'b0, OFS_DONE, 32'h0);
		for (int k = 0; k < 20 && rd[idx] !== 1'b1; k++) apb(1'b0, OFS_DONE, 32'h0);
		chk(rd, 32'(1) << idx);
		apb(1'b0, OFS_DONE, 32'h0);
		chk(rd, 32'(1) << idx);
		apb(1'b1, OFS_REQ, 32'h0);
		for (int k = 0; k < 20 && rd !== 32'h0; k++) apb(1'b0, OFS_DONE, 32'h0);
		chk(rd, 32'h0);
	endtask
	// Set both values, then request the update
	task automatic setg(input int g, input int f, input int d);
		apb(1'b1, 8'(OFS_FREQ + 4 * g), 32'(f));
		apb(1'b1, 8'(OFS_DUTY + 4 * g), 32'(d));
		hs(g, 0);
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, ignored writes and refused addresses
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].wd);
			chk({31'h0, err}, {31'h0, rows[i].e});
			if (!rows[i].w) chk(rd, rows[i].rd);
		end
		// Bad settings raise alarms and leave the defaults running
		foreach (bad[i]) begin
			setg(bad[i][0], bad[i][1], bad[i][2]);
			apb(1'b0, OFS_ALARM, 32'h0);
			chk(rd, 32'(bad[i][3]));
			apb(1'b0, OFS_IOERR, 32'h0);
			chk(rd, 32'(ERR_PARAM));
			hs(bad[i][0], 1);
			apb(1'b0, 8'(OFS_RB + 4 * bad[i][0]), 32'h0);
			chk(rd, 32'h0032_000A);
		end
		apb(1'b1, OFS_IOERR, 32'h0000_0001);
		apb(1'b0, OFS_IOERR, 32'h0);
		chk(rd, 32'h0);
		// Valid settings on every group, read back as a pair
		for (int g = 0; g < 4; g++) begin
			setg(g, 2500, duty[g]);
			hs(g, 1);
			apb(1'b0, 8'(OFS_RB + 4 * g), 32'h0);
			chk(rd, {8'h00, 8'(duty[g]), 16'h09C4});
		end
		apb(1'b0, OFS_ALARM, 32'h0);
		chk(rd, 32'h0);
		// Run all four and measure one full period each
		apb(1'b1, OFS_CTRL, 32'h0000_1111);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h0000_1111);
		wait (per_seen === 4'hF);
		for (int g = 0; g < 4; g++) begin
			chk(per_w[g], CLK_HZ / 2500);
			chk(hi_w[g], (CLK_HZ / 2500) * duty[g] / 100);
		end
		// Stop group 0 only
		apb(1'b1, OFS_CTRL, 32'h0000_1110);
		repeat (2) @(posedge pclk);
		chk(32'(pwm_out[0]), 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h0000_1110);
		// Reset in mid-run
		presetn <= 1'b0;
		@(posedge pclk);
		chk(32'(pwm_out), 32'h0);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFS_FREQ, 32'h0);
		chk(rd, 32'h0000_000A);
		end_of_test();
	end
endmodule
`default_nettype wire
